// File: hw/plc_pkg.sv
// Purpose: shared constants for the latency and refresh configuration block
// Assumes: 40 MHz clock, 16-bit data pins, 22-bit register address field
// Notes:   register select codes, field positions and reset values
`default_nettype none
package plc_pkg;
    // register select codes carried on address bits 19..18
    localparam logic [1:0]  SEL_REFRESH   = 2'h0;
    localparam logic [1:0]  SEL_IDENT     = 2'h1;
    localparam logic [1:0]  SEL_BUSCFG    = 2'h2;
    localparam int          SEL_HI        = 19;
    localparam int          SEL_LO        = 18;
    // software sequence third-cycle data values
    localparam logic [15:0] SW_SEL_REFRESH = 16'h0000;
    localparam logic [15:0] SW_SEL_IDENT   = 16'h0002;
    localparam logic [15:0] SW_SEL_BUSCFG  = 16'h0001;
    // refresh configuration fields
    localparam logic [15:0] REFRESH_RESET = 16'h0010;
    localparam int          RC_PAGE_BIT   = 7;
    localparam int          RC_SLEEP_BIT  = 4;
    localparam logic [15:0] RC_WRITE_MASK = 16'h0097;
    // bus configuration fields
    localparam logic [15:0] BUSCFG_RESET  = 16'h9d1f;
    localparam logic [15:0] BUSCFG_MASK   = 16'hfd7f;
    localparam int          BC_MODE_BIT   = 15;
    localparam int          BC_FIXED_BIT  = 14;
    localparam int          BC_LAT_HI     = 13;
    localparam int          BC_LAT_LO     = 11;
    localparam int          BC_DRIVE_BIT  = 4;
    // region bounds, word addresses
    localparam logic [21:0] ADDR_TOP      = 22'h3fffff;
    localparam logic [21:0] ADDR_HALF     = 22'h200000;
    localparam logic [21:0] ADDR_QUARTER  = 22'h100000;
    localparam logic [21:0] ADDR_EIGHTH   = 22'h080000;
    localparam logic [21:0] ADDR_TOP_QTR  = 22'h300000;
    localparam logic [21:0] ADDR_TOP_8TH  = 22'h380000;
    // wake-up initialization time after deep sleep
    localparam int          WAKE_NS       = 150000;
    localparam int          CLK_NS        = 25;
    localparam int          WAKE_CYCLES   = WAKE_NS / CLK_NS;
    // identification register fields
    localparam int          ID_ROW_BIT    = 15;
endpackage
`default_nettype wire

// File: hw/plc_latency_calc.sv
// Purpose: maps the latency code and type bit to first-data clock counts
// Assumes: code and type come straight from the bus configuration register
// Notes:   reserved codes flag invalid and give a count of zero
`default_nettype none
module plc_latency_calc
    import plc_pkg::*;
(
    // configuration in
    input  wire logic       fixedLat,
    input  wire logic [2:0] latCode,
    input  wire logic       isWrite,
    // counts out
    output logic      [3:0] normalCount,
    output logic      [3:0] worstCount,
    output logic            codeValid
);
    // table lookup kept combinational; the caller registers the result
    always_comb
    begin
        normalCount = 4'h0;
        worstCount  = 4'h0;
        codeValid   = 1'b0;
        if (fixedLat)
        begin
            if (latCode >= 3'h2 && latCode <= 3'h6)
            begin
                normalCount = {1'b0, latCode};
                worstCount  = {1'b0, latCode};
                codeValid   = 1'b1;
            end
        end
        else
        begin
            case (latCode)
                3'h2:
                begin
                    normalCount = 4'h3;
                    worstCount  = 4'h4;
                    codeValid   = 1'b1;
                end
                3'h3:
                begin
                    normalCount = 4'h4;
                    worstCount  = 4'h6;
                    codeValid   = 1'b1;
                end
                3'h4:
                begin
                    normalCount = 4'h5;
                    worstCount  = 4'h8;
                    codeValid   = 1'b1;
                end
                default:
                begin
                    codeValid   = 1'b0;
                end
            endcase
            if (isWrite)
            begin
                worstCount = normalCount;
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/plc_config_top.sv
// Purpose: configuration registers and latency timing of a pseudo-static ram
// Assumes: pins synchronised here; one 40 MHz clock; csLowN active low
// Notes:   data array itself lives outside; this block times and configures
`default_nettype none
module plc_config_top
    import plc_pkg::*;
#(
    parameter int          WAKE_COUNT = WAKE_CYCLES,
    parameter logic [3:0]  ID_VERSION = 4'h9,   // arbitrary value
    parameter logic [2:0]  ID_DENSITY = 3'h5,   // arbitrary value
    parameter logic [2:0]  ID_GENER   = 3'h6,   // arbitrary value
    parameter logic [4:0]  ID_VENDOR  = 5'h1a   // arbitrary value
)
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // memory pins from the controller
    input  wire logic        csLowN,
    input  wire logic        configRegEnablePin,
    input  wire logic        writeLowN,
    input  wire logic        burstStartLowN,
    input  wire logic [21:0] addrPins,
    input  wire logic [15:0] dataIn,
    input  wire logic        refreshBusy,
    input  wire logic        swSeqDone,
    // data pins back to the controller
    output logic      [15:0] dataOut,
    output logic             dataOutEn,
    output logic             waitOut,
    output logic             dataValid,
    // configuration state
    output logic             syncMode,
    output logic             pageModeEn,
    output logic             deepSleep,
    output logic             wakeBusy,
    output logic      [21:0] refreshLow,
    output logic      [21:0] refreshHigh,
    output logic             refreshNone
);
    // two-stage synchronisers for every pin, as one bus
    localparam int PW = 44;
    logic [PW-1:0] pinMeta_q;
    logic [PW-1:0] pinSync_q;
    wire  [PW-1:0] pinRaw = {csLowN, configRegEnablePin, writeLowN,
                             burstStartLowN, addrPins, dataIn,
                             refreshBusy, swSeqDone};

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            pinMeta_q <= {PW{1'b1}};
            pinSync_q <= {PW{1'b1}};
        end
        else
        begin
            pinMeta_q <= pinRaw;
            pinSync_q <= pinMeta_q;
        end
    end

    // unpacked synchronised pins
    wire        csN     = pinSync_q[43];
    wire        cfgPinS = pinSync_q[42];
    wire        weN     = pinSync_q[41];
    wire        advN    = pinSync_q[40];
    wire [21:0] addrS   = pinSync_q[39:18];
    wire [15:0] dataS   = pinSync_q[17:2];
    wire        busyS   = pinSync_q[1];
    wire        swS     = pinSync_q[0];

    // registers
    logic [15:0] busCfg_q;
    logic [15:0] refreshCfg_q;
    logic        csN_q;
    logic        sleep_q;
    logic [17:0] wakeCnt_q;

    wire [15:0] devIdent = {1'b1, ID_VERSION, ID_DENSITY,
                            ID_GENER, ID_VENDOR};

    wire [1:0] pinSel  = addrS[SEL_HI:SEL_LO];
    // software sequence selects from third-cycle data
    wire [1:0] swSel   = (dataS == SW_SEL_IDENT)  ? SEL_IDENT :
                         (dataS == SW_SEL_BUSCFG) ? SEL_BUSCFG : SEL_REFRESH;
    wire       cfgCyc  = ~csN & ((cfgPinS & ~advN) | swS);
    wire [1:0] regSel  = cfgPinS ? pinSel : swSel;
    wire       cfgWr   = cfgCyc & ~weN;
    wire       cfgRd   = cfgCyc & weN;
    wire       wrRefr  = cfgWr & (regSel == SEL_REFRESH);
    wire       wrBus   = cfgWr & (regSel == SEL_BUSCFG);
    // with the pin path the value rides on the address, else on data
    wire [15:0] wrVal  = cfgPinS ? addrS[15:0] : dataS;

    wire [15:0] rdVal  = (regSel == SEL_IDENT)  ? devIdent :
                         (regSel == SEL_BUSCFG) ? busCfg_q : refreshCfg_q;

    // sleep entry on deselect with bit 4 clear
    wire csRise   = csN & ~csN_q;
    wire enterSlp = csRise & ~refreshCfg_q[RC_SLEEP_BIT] & ~sleep_q;
    wire wake     = sleep_q & ~csN;

    // configuration registers
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            refreshCfg_q <= REFRESH_RESET;
            busCfg_q     <= BUSCFG_RESET;
        end
        else if (wake)
        begin
            refreshCfg_q[RC_SLEEP_BIT] <= 1'b1;
            busCfg_q[BC_DRIVE_BIT] <= BUSCFG_RESET[BC_DRIVE_BIT];
        end
        else if (!sleep_q)
        begin
            if (wrRefr)
                refreshCfg_q <= wrVal & RC_WRITE_MASK;
            if (wrBus)
                busCfg_q <= wrVal & BUSCFG_MASK;
        end
    end

    // sleep state and wake-up initialization counter
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            csN_q     <= 1'b1;
            sleep_q   <= 1'b0;
            wakeCnt_q <= 18'h0;
        end
        else
        begin
            csN_q <= csN;
            if (enterSlp)
                sleep_q <= 1'b1;
            else if (wake)
                sleep_q <= 1'b0;
            if (wake)
                wakeCnt_q <= 18'(WAKE_COUNT);
            else if (wakeCnt_q != 18'h0)
                wakeCnt_q <= wakeCnt_q - 18'h1;
        end
    end

    // latency lookup
    logic [3:0] normCnt;
    logic [3:0] worstCnt;
    logic       codeOk;
    plc_latency_calc u_lat
    (
        .fixedLat    (busCfg_q[BC_FIXED_BIT]),
        .latCode     (busCfg_q[BC_LAT_HI:BC_LAT_LO]),
        .isWrite     (~weN),
        .normalCount (normCnt),
        .worstCount  (worstCnt),
        .codeValid   (codeOk)
    );

    // burst latency counter
    logic [3:0] latCnt_q;
    logic [3:0] latTarget_q;
    logic       inBurst_q;
    wire burstGo = ~csN & ~advN & ~cfgPinS & ~busCfg_q[BC_MODE_BIT]
                   & codeOk & ~sleep_q & (wakeCnt_q == 18'h0);
    wire [3:0] target = busyS ? worstCnt : normCnt;
    wire reached = inBurst_q & (latCnt_q == latTarget_q);

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            latCnt_q    <= 4'h0;
            latTarget_q <= 4'h0;
            inBurst_q   <= 1'b0;
        end
        else if (csN)
        begin
            inBurst_q <= 1'b0;
        end
        else if (burstGo)
        begin
            inBurst_q   <= 1'b1;
            latCnt_q    <= 4'h1;
            latTarget_q <= target;
        end
        else if (inBurst_q && !reached)
        begin
            latCnt_q <= latCnt_q + 4'h1;
        end
        // count done: close the burst so data valid is a single strobe
        else if (reached)
        begin
            inBurst_q <= 1'b0;
        end
    end

    // registered pin outputs
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            dataOut   <= 16'h0;
            dataOutEn <= 1'b0;
            waitOut   <= 1'b0;
            dataValid <= 1'b0;
        end
        else
        begin
            dataOut   <= cfgRd ? rdVal : 16'h0;
            dataOutEn <= cfgRd;
            waitOut   <= inBurst_q & ~reached;
            dataValid <= reached;
        end
    end

    wire [2:0] partCode = refreshCfg_q[2:0];
    logic [21:0] lowD;
    always_comb
    begin
        case (partCode)
            3'h1:    lowD = 22'h0;
            3'h2:    lowD = 22'h0;
            3'h3:    lowD = 22'h0;
            3'h5:    lowD = ADDR_HALF;
            3'h6:    lowD = ADDR_TOP_QTR;
            3'h7:    lowD = ADDR_TOP_8TH;
            default: lowD = 22'h0;
        endcase
    end
    wire [21:0] highD = (partCode == 3'h1) ? ADDR_HALF - 22'h1 :
                        (partCode == 3'h2) ? ADDR_QUARTER - 22'h1 :
                        (partCode == 3'h3) ? ADDR_EIGHTH - 22'h1 : ADDR_TOP;

    // status outputs
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            syncMode    <= 1'b0;
            pageModeEn  <= 1'b0;
            deepSleep   <= 1'b0;
            wakeBusy    <= 1'b0;
            refreshLow  <= 22'h0;
            refreshHigh <= ADDR_TOP;
            refreshNone <= 1'b0;
        end
        else
        begin
            syncMode    <= ~busCfg_q[BC_MODE_BIT];
            pageModeEn  <= refreshCfg_q[RC_PAGE_BIT];
            deepSleep   <= sleep_q;
            wakeBusy    <= wakeCnt_q != 18'h0;
            refreshLow  <= lowD;
            refreshHigh <= highD;
            refreshNone <= sleep_q | (partCode == 3'h4);
        end
    end
endmodule
`default_nettype wire

// File: test/plc_config_checker.sv
// Purpose: port-level assertions for the configuration block
// Assumes: one clock domain, asynchronous active-high reset
// Notes:   bound into plc_config_top
`default_nettype none
module plc_config_checker
    import plc_pkg::*;
#(
    parameter int WAKE_COUNT = WAKE_CYCLES
)
(
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // watched pins and state
    input wire logic        csLowN,
    input wire logic [15:0] dataOut,
    input wire logic        dataOutEn,
    input wire logic        waitOut,
    input wire logic        dataValid,
    input wire logic        syncMode,
    input wire logic        pageModeEn,
    input wire logic        deepSleep,
    input wire logic        wakeBusy,
    input wire logic [21:0] refreshLow,
    input wire logic [21:0] refreshHigh,
    input wire logic        refreshNone
);
    timeunit 1ns;
    timeprecision 100ps;
    int wakeCnt_q; // cycles spent in the current wake-up
    // counts wake cycles so the length can be judged at its end
    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
            wakeCnt_q <= 0;
        else
            wakeCnt_q <= wakeBusy ? wakeCnt_q + 1 : 0;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    a_read_idle_zero: assert property (!dataOutEn |-> dataOut == 16'h0000)
        else $error("read data not zero while idle");
    a_range_anchor: assert property (!refreshNone |->
        (refreshLow == 22'h000000 || refreshHigh == 22'h3fffff))
        else $error("refresh range not anchored to an end");
    a_valid_single: assert property (dataValid |=> !dataValid)
        else $error("data valid longer than one cycle");
    a_valid_after_wait: assert property ($rose(dataValid) |-> $past(waitOut))
        else $error("data valid without a latency count");
    a_wait_bound: assert property ($rose(waitOut) |-> ##[1:9] dataValid)
        else $error("latency count did not finish in bound");
    a_burst_sync: assert property ($rose(waitOut) |-> syncMode)
        else $error("burst latency started in asynchronous mode");
    a_sleep_entry: assert property ($rose(deepSleep) |-> csLowN && $past(csLowN, 2))
        else $error("deep sleep entered with chip selected");
    a_sleep_quiet: assert property (deepSleep |-> !dataOutEn && !waitOut)
        else $error("activity while in deep sleep");
    a_wake_busy: assert property ($fell(deepSleep) |-> ##[0:1] wakeBusy)
        else $error("no wake-up init after leaving sleep");
    a_wake_length: assert property ($fell(wakeBusy) |->
        wakeCnt_q >= WAKE_COUNT - 1 && wakeCnt_q <= WAKE_COUNT + 1)
        else $error("wake-up init length wrong");
    a_sleep_keeps: assert property (deepSleep |-> $stable(pageModeEn))
        else $error("page mode changed during sleep");
    c_burst: cover property ($rose(dataValid));
    c_sleep: cover property ($rose(deepSleep));
    c_no_refresh: cover property ($rose(refreshNone));
endmodule
bind plc_config_top plc_config_checker #(.WAKE_COUNT(WAKE_COUNT))
    u_plc_config_checker (.clk(clk), .reset(reset), .csLowN(csLowN),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .waitOut(waitOut),
    .dataValid(dataValid), .syncMode(syncMode), .pageModeEn(pageModeEn),
    .deepSleep(deepSleep), .wakeBusy(wakeBusy), .refreshLow(refreshLow),
    .refreshHigh(refreshHigh), .refreshNone(refreshNone));
`default_nettype wire

// File: test/plc_host_model.sv
// Purpose: memory controller model driving the configuration pins
// Assumes: pins change just after a rising edge and hold until sampled
// Notes:   idle data pins toggle so a stale value never looks valid
`default_nettype none
module plc_host_model
    import plc_pkg::*;
(
    // clock
    input wire logic         clk,
    // pins toward the device
    output logic             csLowN = 1'b0,
    output logic             configRegEnablePin = 1'b0,
    output logic             writeLowN = 1'b1,
    output logic             burstStartLowN = 1'b1,
    output logic      [21:0] addrPins = 22'h000000,
    output logic      [15:0] dataIn = 16'h5a5a,
    output logic             refreshBusy = 1'b0,
    output logic             swSeqDone = 1'b0,
    // answers from the device
    input wire logic  [15:0] dataOut,
    input wire logic         dataValid,
    input wire logic         wakeBusy
);
    timeunit 1ns;
    timeprecision 100ps;
    // one set of strobe levels, launched just after an edge
    task automatic pins(input logic cfg, bst, wr, sw, busy);
        @(posedge clk);
        configRegEnablePin <= cfg;
        burstStartLowN     <= !bst;
        writeLowN          <= !wr;
        swSeqDone          <= sw;
        refreshBusy        <= busy;
    endtask
    // bus released; long enough for the pin synchronisers to drain
    task automatic idle(input int n);
        pins(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        repeat (n)
        begin
            @(posedge clk);
            dataIn <= ~dataIn;
        end
    endtask
    task automatic regAccess(input logic [1:0] sel, input logic wr,
                             input logic [15:0] val, output logic [15:0] rd);
        pins(1'b1, 1'b1, wr, 1'b0, 1'b0);
        addrPins <= {2'h0, sel, 2'h0, val};
        repeat (4) @(posedge clk);
        rd = dataOut;
        idle(3);
    endtask
    task automatic swRead(input logic [15:0] code, output logic [15:0] rd);
        pins(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        dataIn <= code;
        repeat (4) @(posedge clk);
        rd = dataOut;
        idle(3);
    endtask
    // waits on the device, never on a guessed count
    task automatic burst(input logic wr, busy, output int delay);
        pins(1'b0, 1'b1, wr, 1'b0, busy);
        delay = 0;
        do
        begin
            @(posedge clk);
            // start is a one-cycle strobe; held low it would re-arm
            burstStartLowN <= 1'b1;
            delay++;
        end
        while (dataValid !== 1'b1 && delay < 40);
        idle(12);
    endtask
    // chip select level, then a fixed settle time
    task automatic csLevel(input logic v, input int n);
        @(posedge clk);
        csLowN <= v;
        repeat (n) @(posedge clk);
    endtask
    // no access until wake-up init is over
    task automatic waitWake();
        int n;
        n = 0;
        while (wakeBusy !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            n++;
        end
    endtask
endmodule
`default_nettype wire

// File: test/test_psram_latency_refresh_config.sv
// Purpose: self-checking bench for the configuration block
// Assumes: 40 MHz clock, short wake-up count for simulation
// Notes:   burst delays are judged against a fixed-latency reference
`default_nettype none
module test_psram_latency_refresh_config;
    timeunit 1ns;
    timeprecision 100ps;
    import plc_pkg::*;
    logic clk = 1'b0, reset = 1'b1, csLowN, cfgPin, writeLowN, burstN;
    logic refreshBusy, swSeqDone, dataOutEn, waitOut, dataValid, syncMode;
    logic pageModeEn, deepSleep, wakeBusy, refreshNone;
    logic [21:0] addrPins, refreshLow, refreshHigh;
    logic [15:0] dataIn, dataOut, rd;
    int badCount = 0, nChecks = 0, base, d, c;
    // ident fields below are arbitrary values
    localparam logic [15:0] IDENT = {1'b1, 4'h3, 3'h6, 3'h5, 5'h0c};
    localparam logic [21:0] LOW[8] = '{0, 0, 0, 0, 0, 22'h200000,
                                      22'h300000, 22'h380000};
    localparam logic [21:0] HIGH[8] = '{22'h3fffff, 22'h1fffff, 22'h0fffff,
        22'h07ffff, 0, 22'h3fffff, 22'h3fffff, 22'h3fffff};
    // fixed, code, write, collision, expected count (one hex digit each)
    localparam int CASES[11] = '{'h14004, 'h15005, 'h16006, 'h14014,
        'h02003, 'h03004, 'h04005, 'h02014, 'h03016, 'h04018, 'h04105};
    always #12.5 clk = ~clk;
    plc_config_top #(.WAKE_COUNT(20), .ID_VERSION(4'h3), .ID_DENSITY(3'h6),
        .ID_GENER(3'h5), .ID_VENDOR(5'h0c)) u_plc_config_top (.clk(clk),
        .reset(reset), .csLowN(csLowN), .configRegEnablePin(cfgPin),
        .writeLowN(writeLowN), .burstStartLowN(burstN), .addrPins(addrPins),
        .dataIn(dataIn), .refreshBusy(refreshBusy), .swSeqDone(swSeqDone),
        .dataOut(dataOut), .dataOutEn(dataOutEn), .waitOut(waitOut),
        .dataValid(dataValid), .syncMode(syncMode), .pageModeEn(pageModeEn),
        .deepSleep(deepSleep), .wakeBusy(wakeBusy), .refreshLow(refreshLow),
        .refreshHigh(refreshHigh), .refreshNone(refreshNone));
    plc_host_model u_plc_host_model (.clk(clk), .csLowN(csLowN),
        .configRegEnablePin(cfgPin), .writeLowN(writeLowN),
        .burstStartLowN(burstN), .addrPins(addrPins), .dataIn(dataIn),
        .refreshBusy(refreshBusy), .swSeqDone(swSeqDone), .dataOut(dataOut),
        .dataValid(dataValid), .wakeBusy(wakeBusy));
    // compares one observed value, counting every call
    task automatic check(input string what, input logic [21:0] seen, exp);
        nChecks++;
        if (seen !== exp)
        begin
            badCount++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // verdict and end of run
    task automatic completeRun();
        if (badCount == 0 && nChecks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        repeat (2) @(posedge clk);
        u_plc_host_model.regAccess(SEL_REFRESH, 1'b0, 16'h0, rd);
        check("refresh reset", 22'(rd), 22'h0010);
        check("page mode", 22'(pageModeEn), 22'h0);
        u_plc_host_model.regAccess(SEL_BUSCFG, 1'b0, 16'h0, rd);
        check("bus cfg reset", 22'(rd), 22'h9d1f);
        check("sync mode", 22'(syncMode), 22'h0);
        u_plc_host_model.regAccess(SEL_IDENT, 1'b1, 16'h0000, rd);
        u_plc_host_model.regAccess(SEL_IDENT, 1'b0, 16'h0, rd);
        check("ident pin", 22'(rd), 22'(IDENT));
        u_plc_host_model.swRead(SW_SEL_IDENT, rd);
        check("ident seq", 22'(rd), 22'(IDENT));
        u_plc_host_model.regAccess(SEL_REFRESH, 1'b1, 16'h00ff, rd);
        u_plc_host_model.swRead(SW_SEL_REFRESH, rd);
        check("refresh masked", 22'(rd), 22'h0097);
        check("page mode on", 22'(pageModeEn), 22'h1);
        for (int i = 0; i < 8; i++)
        begin
            u_plc_host_model.regAccess(SEL_REFRESH, 1'b1, 16'(16 + i), rd);
            check("refresh none", 22'(refreshNone), 22'(i == 4));
            if (i != 4)
            begin
                check("range low", refreshLow, LOW[i]);
                check("range high", refreshHigh, HIGH[i]);
            end
        end
        u_plc_host_model.regAccess(SEL_BUSCFG, 1'b1, 16'h581f, rd);
        check("sync mode on", 22'(syncMode), 22'h1);
        u_plc_host_model.burst(1'b0, 1'b0, base);
        for (int k = 0; k < 11; k++)
        begin
            c = CASES[k];
            u_plc_host_model.regAccess(SEL_BUSCFG, 1'b1,
                {1'b0, c[16], c[14:12], 11'h01f}, rd);
            u_plc_host_model.burst(c[8], c[4], d);
            check("latency", 22'(d), 22'(base + c[3:0] - 3));
        end
        u_plc_host_model.regAccess(SEL_BUSCFG, 1'b1, 16'h1c0f, rd);
        u_plc_host_model.regAccess(SEL_REFRESH, 1'b1, 16'h0081, rd);
        u_plc_host_model.csLevel(1'b1, 6);
        check("sleep entered", 22'(deepSleep), 22'h1);
        u_plc_host_model.csLevel(1'b0, 5);
        check("sleep left", 22'(deepSleep), 22'h0);
        check("wake busy", 22'(wakeBusy), 22'h1);
        u_plc_host_model.waitWake();
        check("wake done", 22'(wakeBusy), 22'h0);
        u_plc_host_model.regAccess(SEL_REFRESH, 1'b0, 16'h0, rd);
        check("refresh kept", 22'(rd), 22'h0091);
        u_plc_host_model.regAccess(SEL_BUSCFG, 1'b0, 16'h0, rd);
        check("bus cfg kept", 22'(rd), 22'h1c1f);
        completeRun();
    end
    // watchdog, well beyond the expected run length
    initial
    begin
        #(25 * 6000);
        badCount++;
        completeRun();
    end
endmodule
`default_nettype wire
